//--- shared/tpc_pkg.sv
// tpc_pkg: register map, reset values, field positions and shared types of
// the transmit packet configuration block.
// assumes an spi host that sends a header byte {rw, burst, addr[5:0]} first.
package tpc_pkg;

  // register addresses on the spi header
  localparam logic [5:0] ADDR_MARKER_HIGH  = 6'h04;
  localparam logic [5:0] ADDR_MARKER_LOW   = 6'h05;
  localparam logic [5:0] ADDR_PKT_LENGTH   = 6'h06;
  localparam logic [5:0] ADDR_PKT_CONTROL  = 6'h08;
  localparam logic [5:0] ADDR_NODE         = 6'h09;
  localparam logic [5:0] ADDR_HOP          = 6'h0a;
  localparam logic [5:0] ADDR_CARRIER_HIGH = 6'h0d;

  // reset values
  localparam logic [7:0] RST_MARKER_HIGH   = 8'hd3;
  localparam logic [7:0] RST_MARKER_LOW    = 8'h91;
  localparam logic [7:0] RST_PKT_LENGTH    = 8'hff;
  localparam logic       RST_WHITEN        = 1'h1;
  localparam logic       RST_CRC_EN        = 1'h1;
  localparam logic [7:0] RST_NODE          = 8'h00;
  localparam logic [7:0] RST_HOP           = 8'h00;
  localparam logic [5:0] RST_CARRIER_HIGH  = 6'h1e;

  // packet control field positions
  localparam int CTRL_WHITEN_BIT = 6;
  localparam int CTRL_SRC_MSB    = 5;
  localparam int CTRL_SRC_LSB    = 4;
  localparam int CTRL_CRC_BIT    = 2;
  localparam int CTRL_LEN_MSB    = 1;
  localparam int CTRL_LEN_LSB    = 0;
  localparam int CARRIER_HIGH_MSB = 5;

  // spi header fields
  localparam int SPI_RW_BIT    = 7;
  localparam int SPI_BURST_BIT = 6;

  // check sequence and whitening generator
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [8:0]  PN9_SEED = 9'h1ff;
  localparam int          PN9_TAP  = 5;

  typedef enum logic [1:0] {SRC_FIFO, SRC_SYNC_SERIAL, SRC_PN9, SRC_ASYNC} tpc_src_t;
  typedef enum logic [1:0] {LEN_FIXED, LEN_VARIABLE, LEN_INFINITE, LEN_RESERVED} tpc_len_t;
  typedef enum logic [2:0] {FR_IDLE, FR_MARKER, FR_LENGTH, FR_PAYLOAD, FR_CHECK,
                            FR_STREAM} tpc_frame_t;

  typedef struct packed {
    logic [7:0] marker_word_high;
    logic [7:0] marker_word_low;
    logic [7:0] packet_length_limit;
    logic       whitening_enable;
    tpc_src_t   tx_data_source_select;
    logic       crc_enable;
    tpc_len_t   length_config;
    logic [7:0] node_address;
    logic [7:0] hop_index_value;
    logic [5:0] carrier_base_word_high;
  } tpc_cfg_t;

  localparam tpc_cfg_t CFG_RST = '{
    marker_word_high:       RST_MARKER_HIGH,
    marker_word_low:        RST_MARKER_LOW,
    packet_length_limit:    RST_PKT_LENGTH,
    whitening_enable:       RST_WHITEN,
    tx_data_source_select:  SRC_FIFO,
    crc_enable:             RST_CRC_EN,
    length_config:          LEN_VARIABLE,
    node_address:           RST_NODE,
    hop_index_value:        RST_HOP,
    carrier_base_word_high: RST_CARRIER_HIGH
  };

  typedef struct packed {
    tpc_cfg_t   cfg;
    logic       sck_prev;
    logic       cs_n_prev;
    logic       en_prev;
    logic [2:0] spi_cnt;
    logic [6:0] spi_shift;
    logic       hdr_done;
    logic       is_read;
    logic       burst;
    logic [5:0] addr;
    logic [7:0] out_shift;
    logic       miso;
    tpc_frame_t st;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] bytes_left;
    logic       second;
    logic [15:0] crc;
    logic [8:0] pn;
    logic       tx_bit;
    logic       underflow;
    logic [8:0] taken_cnt;
  } tpc_state_t;

endpackage

//--- verilog/tpc_top.sv
// tpc_top: spi register slave for the packet configuration registers and
// the bit-serial transmit framer that those registers steer.
// assumes spi pins and bit_tick_in are synchronous to mclk_in, sck idles low.
// Function
// - marker low byte register, reset 0x91
// - marker high byte register, reset 0xd3
// - fixed mode sends exactly limit payload bytes
// - variable mode caps length at limit
// - bit 6 enables whitening, reset on
// - source 00 fifo, 01 synchronous serial pin
// - source 10 sends pn9 test data
// - source 11 asynchronous transparent from pin
// - bit 2 enables check sequence, reset on
// - length field 00 means fixed length
// - length field 01 variable, first byte
// - length field 10 infinite, 11 reserved
// - node address register, reset zero
// - hop index register, reset zero
// - carrier word bits 23:22 read zero
// - carrier word bits 21:16 writable, reset 0x1e
module tpc_top #(
  parameter logic [15:0] CRC_POLY_P = tpc_pkg::CRC_POLY
) (
  input  wire logic            mclk_in,
  input  wire logic            rst_n_in,
  input  wire logic            cs_n_in,
  input  wire logic            sck_in,
  input  wire logic            mosi_in,
  output logic                 miso_out,
  output logic                 miso_oe_out,
  input  wire logic            tx_enable_in,
  input  wire logic            bit_tick_in,
  input  wire logic [7:0]      fifo_data_in,
  input  wire logic            fifo_valid_in,
  output logic                 fifo_ready_out,
  input  wire logic            general_output_pin_zero_in,
  output logic                 tx_bit_out,
  output logic                 tx_active_out,
  output logic                 underflow_out,
  output tpc_pkg::tpc_cfg_t    cfg_out
);

  // a generator polynomial without the constant term is not a valid check
  if (CRC_POLY_P[0] != 1'b1) begin : g_poly_check
    $error("crc polynomial must have bit 0 set");
  end

  tpc_pkg::tpc_state_t s;
  tpc_pkg::tpc_state_t next_s;

  logic       sck_rise;
  logic       sck_fall;
  logic       framed;
  logic       byte_end;
  logic       is_var;
  logic       is_inf;
  logic       is_fixed;
  logic       more_payload;
  logic       want_fifo;
  logic       whiten_now;
  logic       crc_now;
  logic       bit_now;
  logic [7:0] pay_count;
  logic [7:0] status_byte;
  logic [7:0] ctrl_read;
  logic [7:0] carrier_read;

  function automatic logic [7:0] reg_read(input tpc_pkg::tpc_cfg_t c, input logic [5:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == tpc_pkg::ADDR_MARKER_HIGH) begin
      d = c.marker_word_high;
    end else if (a == tpc_pkg::ADDR_MARKER_LOW) begin
      d = c.marker_word_low;
    end else if (a == tpc_pkg::ADDR_PKT_LENGTH) begin
      d = c.packet_length_limit;
    end else if (a == tpc_pkg::ADDR_PKT_CONTROL) begin
      // bits 7 and 3 stay zero
      d[tpc_pkg::CTRL_WHITEN_BIT] = c.whitening_enable;
      d[tpc_pkg::CTRL_SRC_MSB:tpc_pkg::CTRL_SRC_LSB] = c.tx_data_source_select;
      d[tpc_pkg::CTRL_CRC_BIT] = c.crc_enable;
      d[tpc_pkg::CTRL_LEN_MSB:tpc_pkg::CTRL_LEN_LSB] = c.length_config;
    end else if (a == tpc_pkg::ADDR_NODE) begin
      d = c.node_address;
    end else if (a == tpc_pkg::ADDR_HOP) begin
      d = c.hop_index_value;
    end else if (a == tpc_pkg::ADDR_CARRIER_HIGH) begin
      d = {2'h0, c.carrier_base_word_high}; // top two bits read zero
    end
    return d;
  endfunction

  function automatic tpc_pkg::tpc_cfg_t reg_write(input tpc_pkg::tpc_cfg_t c,
                                                  input logic [5:0] a, input logic [7:0] d);
    tpc_pkg::tpc_cfg_t r;
    r = c;
    if (a == tpc_pkg::ADDR_MARKER_HIGH) begin
      r.marker_word_high = d;
    end else if (a == tpc_pkg::ADDR_MARKER_LOW) begin
      r.marker_word_low = d;
    end else if (a == tpc_pkg::ADDR_PKT_LENGTH) begin
      r.packet_length_limit = d;
    end else if (a == tpc_pkg::ADDR_PKT_CONTROL) begin
      r.whitening_enable = d[tpc_pkg::CTRL_WHITEN_BIT];
      r.tx_data_source_select =
        tpc_pkg::tpc_src_t'(d[tpc_pkg::CTRL_SRC_MSB:tpc_pkg::CTRL_SRC_LSB]);
      r.crc_enable = d[tpc_pkg::CTRL_CRC_BIT];
      r.length_config = tpc_pkg::tpc_len_t'(d[tpc_pkg::CTRL_LEN_MSB:tpc_pkg::CTRL_LEN_LSB]);
    end else if (a == tpc_pkg::ADDR_NODE) begin
      r.node_address = d; // kept for packet filtering downstream
    end else if (a == tpc_pkg::ADDR_HOP) begin
      r.hop_index_value = d; // scaled by spacing downstream
    end else if (a == tpc_pkg::ADDR_CARRIER_HIGH) begin
      r.carrier_base_word_high = d[tpc_pkg::CARRIER_HIGH_MSB:0];
    end
    return r;
  endfunction

  // x^9 + x^5 + 1, shared by whitening and the random test source
  function automatic logic [8:0] pn9_step(input logic [8:0] p);
    return {p[0] ^ p[tpc_pkg::PN9_TAP], p[8:1]};
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY_P : 16'h0000);
  endfunction

  // pin edges and frame decode
  assign sck_rise    = sck_in & ~s.sck_prev;
  assign sck_fall    = ~sck_in & s.sck_prev;
  assign status_byte = {1'b0, s.st != tpc_pkg::FR_IDLE, 6'h00};
  assign is_var      = s.cfg.length_config == tpc_pkg::LEN_VARIABLE;
  assign is_inf      = s.cfg.length_config == tpc_pkg::LEN_INFINITE;
  // reserved setting falls back to fixed so the frame always ends
  assign is_fixed    = ~is_var & ~is_inf;
  assign framed      = (s.st == tpc_pkg::FR_MARKER) | (s.st == tpc_pkg::FR_LENGTH) |
                       (s.st == tpc_pkg::FR_PAYLOAD) | (s.st == tpc_pkg::FR_CHECK);
  assign byte_end    = framed & bit_tick_in & (s.bit_cnt == 3'h7);
  // fixed frames count from the limit, variable ones from the length byte
  assign pay_count   = (s.st == tpc_pkg::FR_MARKER) ? s.cfg.packet_length_limit
                                                    : s.bytes_left;
  assign more_payload = is_inf ? tx_enable_in : (pay_count != 8'h00);
  assign want_fifo   = byte_end & ((s.st == tpc_pkg::FR_MARKER) ?
                       (s.second & (is_var | more_payload)) :
                       (((s.st == tpc_pkg::FR_LENGTH) | (s.st == tpc_pkg::FR_PAYLOAD))
                        & more_payload));
  assign whiten_now  = s.cfg.whitening_enable & framed & (s.st != tpc_pkg::FR_MARKER);
  assign crc_now     = s.cfg.crc_enable &
                       ((s.st == tpc_pkg::FR_LENGTH) | (s.st == tpc_pkg::FR_PAYLOAD));
  assign bit_now     = s.sh[7] ^ (whiten_now & s.pn[0]);

  // next state: spi slave, then the framer
  always_comb begin
    logic [7:0] rx_byte;
    logic [7:0] len_byte;
    rx_byte  = {s.spi_shift, mosi_in};
    len_byte = 8'h00;
    next_s = s;
    next_s.sck_prev  = sck_in;
    next_s.cs_n_prev = cs_n_in;
    next_s.en_prev   = tx_enable_in;
    if (cs_n_in) begin
      next_s.spi_cnt  = 3'h0;
      next_s.hdr_done = 1'b0;
      next_s.miso     = 1'b0;
    end else if (s.cs_n_prev) begin
      // status byte goes out while the header comes in
      next_s.miso      = status_byte[7];
      next_s.out_shift = {status_byte[6:0], 1'b0};
    end else if (sck_rise) begin
      next_s.spi_shift = rx_byte[6:0];
      next_s.spi_cnt   = s.spi_cnt + 3'h1;
      if (s.spi_cnt == 3'h7) begin
        if (!s.hdr_done) begin
          next_s.hdr_done  = 1'b1;
          next_s.is_read   = rx_byte[tpc_pkg::SPI_RW_BIT];
          next_s.burst     = rx_byte[tpc_pkg::SPI_BURST_BIT];
          next_s.addr      = rx_byte[5:0];
          next_s.out_shift = reg_read(s.cfg, rx_byte[5:0]);
        end else begin
          if (!s.is_read) begin
            next_s.cfg = reg_write(s.cfg, s.addr, rx_byte);
          end
          // burst walks the map; a single access waits for a new header
          if (s.burst) begin
            next_s.addr      = s.addr + 6'h01;
            next_s.out_shift = reg_read(next_s.cfg, s.addr + 6'h01);
          end else begin
            next_s.hdr_done = 1'b0;
          end
        end
      end
    end else if (sck_fall) begin
      next_s.miso      = s.out_shift[7];
      next_s.out_shift = {s.out_shift[6:0], 1'b0};
    end

    case (s.st)
      tpc_pkg::FR_IDLE: begin
        if (tx_enable_in && !s.en_prev &&
            s.cfg.tx_data_source_select == tpc_pkg::SRC_FIFO) begin
          next_s.st        = tpc_pkg::FR_MARKER;
          next_s.sh        = s.cfg.marker_word_high;
          next_s.second    = 1'b0;
          next_s.bit_cnt   = 3'h0;
          next_s.crc       = tpc_pkg::CRC_INIT;
          next_s.pn        = tpc_pkg::PN9_SEED;
          next_s.underflow = 1'b0;
          next_s.taken_cnt = 9'h000;
        end else if (tx_enable_in &&
                     s.cfg.tx_data_source_select != tpc_pkg::SRC_FIFO) begin
          next_s.st = tpc_pkg::FR_STREAM;
          next_s.pn = tpc_pkg::PN9_SEED;
        end
      end
      tpc_pkg::FR_STREAM: begin
        if (!tx_enable_in) begin
          next_s.st = tpc_pkg::FR_IDLE;
        end else if (s.cfg.tx_data_source_select == tpc_pkg::SRC_SYNC_SERIAL) begin
          if (bit_tick_in) begin
            next_s.tx_bit = general_output_pin_zero_in;
          end
        end else if (s.cfg.tx_data_source_select == tpc_pkg::SRC_PN9) begin
          if (bit_tick_in) begin
            next_s.tx_bit = s.pn[0];
            next_s.pn     = pn9_step(s.pn);
          end
        end else if (s.cfg.tx_data_source_select == tpc_pkg::SRC_ASYNC) begin
          // no bit timing: the pin passes through at clock rate
          next_s.tx_bit = general_output_pin_zero_in;
        end else begin
          next_s.st = tpc_pkg::FR_IDLE;
        end
      end
      default: begin
        if (bit_tick_in) begin
          next_s.tx_bit  = bit_now;
          next_s.sh      = {s.sh[6:0], 1'b0};
          next_s.bit_cnt = s.bit_cnt + 3'h1;
          if (whiten_now) begin
            next_s.pn = pn9_step(s.pn);
          end
          if (crc_now) begin
            next_s.crc = crc_step(s.crc, s.sh[7]); // check over raw bits
          end
        end
        if (byte_end) begin
          if (s.st == tpc_pkg::FR_CHECK) begin
            if (!s.second) begin
              next_s.second = 1'b1;
              next_s.sh     = s.crc[7:0];
            end else begin
              next_s.st = tpc_pkg::FR_IDLE;
            end
          end else if (s.st == tpc_pkg::FR_MARKER && !s.second) begin
            next_s.second = 1'b1;
            next_s.sh     = s.cfg.marker_word_low;
          end else begin
            next_s.second = 1'b0;
            if (want_fifo) begin
              if (!fifo_valid_in) begin
                // starved mid-frame: abandon rather than send stale bytes
                next_s.underflow = 1'b1;
                next_s.st        = tpc_pkg::FR_IDLE;
              end else if (s.st == tpc_pkg::FR_MARKER && is_var) begin
                len_byte = (fifo_data_in > s.cfg.packet_length_limit) ?
                           s.cfg.packet_length_limit : fifo_data_in;
                next_s.sh         = len_byte;
                next_s.bytes_left = len_byte;
                next_s.st         = tpc_pkg::FR_LENGTH;
                next_s.taken_cnt  = s.taken_cnt + 9'h001;
              end else begin
                next_s.sh         = fifo_data_in;
                next_s.bytes_left = is_inf ? s.bytes_left : pay_count - 8'h01;
                next_s.st         = tpc_pkg::FR_PAYLOAD;
                next_s.taken_cnt  = s.taken_cnt + 9'h001;
              end
            end else if (s.cfg.crc_enable && !is_inf) begin
              next_s.st = tpc_pkg::FR_CHECK;
              next_s.sh = next_s.crc[15:8];
            end else begin
              next_s.st = tpc_pkg::FR_IDLE;
            end
          end
        end
      end
    endcase
  end

  // single state register; reset gives the documented register defaults
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s     <= '0;
      s.cfg <= tpc_pkg::CFG_RST;
    end else begin
      s <= next_s;
    end
  end

  assign miso_out       = s.miso;
  assign miso_oe_out    = ~cs_n_in;
  assign fifo_ready_out = want_fifo;
  assign tx_bit_out     = s.tx_bit;
  assign tx_active_out  = s.st != tpc_pkg::FR_IDLE;
  assign underflow_out  = s.underflow;
  assign cfg_out        = s.cfg;

  // read views for the read-as-zero checks; a select on a call is not legal
  assign ctrl_read      = reg_read(s.cfg, tpc_pkg::ADDR_PKT_CONTROL);
  assign carrier_read   = reg_read(s.cfg, tpc_pkg::ADDR_CARRIER_HIGH);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_marker_low_rst: assert property ($past(!rst_n_in) |-> s.cfg.marker_word_low == 8'h91)
    else $error("marker low byte reset value wrong");
  a_marker_high_rst: assert property ($past(!rst_n_in) |-> s.cfg.marker_word_high == 8'hd3)
    else $error("marker high byte reset value wrong");
  a_fixed_count: assert property ((byte_end && is_fixed && !want_fifo &&
      (s.st == tpc_pkg::FR_PAYLOAD || (s.st == tpc_pkg::FR_MARKER && s.second)))
      |-> s.taken_cnt == {1'b0, s.cfg.packet_length_limit})
    else $error("fixed frame byte count differs from limit");
  a_var_cap: assert property ((s.st == tpc_pkg::FR_LENGTH) && $changed(s.st)
      |-> s.sh <= s.cfg.packet_length_limit)
    else $error("length byte exceeds limit");
  a_plain_bits: assert property ((bit_tick_in && s.st == tpc_pkg::FR_PAYLOAD &&
      !s.cfg.whitening_enable) |=> tx_bit_out == $past(s.sh[7]))
    else $error("unwhitened bit differs from payload bit");
  a_sync_serial: assert property ((s.st == tpc_pkg::FR_STREAM && tx_enable_in && bit_tick_in &&
      s.cfg.tx_data_source_select == tpc_pkg::SRC_SYNC_SERIAL)
      |=> tx_bit_out == $past(general_output_pin_zero_in))
    else $error("serial source bit not taken from pin");
  a_pn9_stream: assert property ((s.st == tpc_pkg::FR_STREAM && tx_enable_in && bit_tick_in &&
      s.cfg.tx_data_source_select == tpc_pkg::SRC_PN9) |=> tx_bit_out == $past(s.pn[0]))
    else $error("random source bit wrong");
  a_async_pass: assert property ((s.st == tpc_pkg::FR_STREAM && tx_enable_in &&
      s.cfg.tx_data_source_select == tpc_pkg::SRC_ASYNC)
      |=> tx_bit_out == $past(general_output_pin_zero_in))
    else $error("transparent bit not following pin");
  a_no_check: assert property (!s.cfg.crc_enable |=> s.st != tpc_pkg::FR_CHECK ||
      $past(s.st) == tpc_pkg::FR_CHECK)
    else $error("check sequence sent while disabled");
  a_ctrl_zero: assert property (ctrl_read[7] == 1'b0 && ctrl_read[3] == 1'b0)
    else $error("unused control bits read nonzero");
  a_carrier_top: assert property (carrier_read[7:6] == 2'h0)
    else $error("carrier word top bits read nonzero");

  c_fixed_frame: cover property (s.st == tpc_pkg::FR_CHECK && is_fixed ##1 s.st == tpc_pkg::FR_IDLE);
  c_var_frame: cover property (s.st == tpc_pkg::FR_LENGTH ##[1:300] s.st == tpc_pkg::FR_CHECK);
  c_underflow: cover property ($rose(s.underflow));
  c_spi_write: cover property (sck_rise && s.hdr_done && !s.is_read && s.spi_cnt == 3'h7);

endmodule

//--- test/tpc_host_model.sv
// tpc_host_model: spi host that programs the packet configuration block.
// assumes mode 0 and a design that needs at least 2 mclk per sck phase.
module tpc_host_model (
  input  wire logic mclk_in,
  input  wire logic miso_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      mosi_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus: deselected, clock low
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    mosi_out = 1'b0;
  end

  // header then one data byte, msb first; low phase is 3 cycles so miso
  // has settled two cycles before it is sampled at the rise
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {hdr, wd};
    rd = 8'h00;
    @(posedge mclk_in) cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out <= sh[i];
      repeat (3) @(posedge mclk_in);
      sck_out <= 1'b1;
      if (i < 8) rd = {rd[6:0], miso_in};
      repeat (2) @(posedge mclk_in);
      sck_out <= 1'b0;
    end
    repeat (2) @(posedge mclk_in);
    cs_n_out <= 1'b1;
    mosi_out <= ~mosi_out;  // released line shows no stale value
    repeat (2) @(posedge mclk_in);
  endtask
endmodule

//--- test/tx_packet_config_regs_tb.sv
// tx_packet_config_regs_tb: self-checking bench for the configuration block.
// assumes the host model drives the spi pins and the bench the framer side.
module tx_packet_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              cs_n, sck, mosi, miso, tx_bit_out, tx_active_out, underflow_out;
  logic              fifo_ready_out, tx_enable_in = 1'b0, bit_tick_in = 1'b0;
  logic              fifo_valid_in = 1'b1, pin_in = 1'b0;
  logic [7:0]        fifo_data_in = 8'h00;
  logic [7:0]        d;
  logic [8:0]        pn;
  tpc_pkg::tpc_cfg_t cfg_out;
  integer            seed = 32'h9970;
  int                num_errors = 0, checks_done = 0, takes = 0, cycles = 0;
  logic [5:0]        ra[7] = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a, 6'h0d};
  logic [7:0]        rv[7] = '{8'hd3, 8'h91, 8'hff, 8'h45, 8'h00, 8'h00, 8'h1e};
  logic [7:0]        rm[7] = '{8'hff, 8'hff, 8'hff, 8'h77, 8'hff, 8'hff, 8'h3f};

  tpc_host_model host (.mclk_in(mclk_in), .miso_in(miso), .cs_n_out(cs_n),
                       .sck_out(sck), .mosi_out(mosi));
  tpc_top uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sck_in(sck),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(), .tx_enable_in(tx_enable_in),
    .bit_tick_in(bit_tick_in), .fifo_data_in(fifo_data_in), .fifo_valid_in(fifo_valid_in),
    .fifo_ready_out(fifo_ready_out), .general_output_pin_zero_in(pin_in),
    .tx_bit_out(tx_bit_out), .tx_active_out(tx_active_out),
    .underflow_out(underflow_out), .cfg_out(cfg_out));

  always #2.5 mclk_in = ~mclk_in;

  // count bytes taken from the fifo; the ceiling is far above the run length
  always @(posedge mclk_in) begin
    cycles++;
    if (fifo_ready_out && fifo_valid_in) takes++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // expected test source: x^9 + x^5 + 1, bit sent is the lsb
  function automatic logic [8:0] pn9_next(input logic [8:0] p);
    return {p[0] ^ p[tpc_pkg::PN9_TAP], p[8:1]};
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] r;
    host.xfer({2'b00, a}, v, r);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer({2'b10, a}, 8'h00, r);
    check(64'(r), 64'(e));
  endtask

  // one bit period; the transmit bit is read two cycles after the tick
  task automatic tick();
    bit_tick_in <= 1'b1;
    @(posedge mclk_in) bit_tick_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask

  // one fifo frame with whitening and check bytes off; the fifo byte is
  // always above the limit so a variable length byte must be clipped
  task automatic frame(input logic [1:0] lc);
    logic [7:0] q[$];
    logic [7:0] b, lim;
    lim = 8'h01 + 8'($random(seed) & 1);
    b = 8'($random(seed)) | 8'h04;
    wr(tpc_pkg::ADDR_PKT_LENGTH, lim);
    wr(tpc_pkg::ADDR_PKT_CONTROL, {6'h00, lc});
    fifo_data_in <= b;
    q = '{tpc_pkg::RST_MARKER_HIGH, tpc_pkg::RST_MARKER_LOW};
    if (lc == 2'b01) q.push_back(lim);
    repeat ((lc == 2'b10) ? 3 : lim) q.push_back(b);
    takes = 0;
    tx_enable_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    foreach (q[k]) for (int i = 7; i >= 0; i--) begin
      if (lc == 2'b10 && k == 4 && i == 3) tx_enable_in <= 1'b0;
      tick();
      check(64'(tx_bit_out), 64'(q[k][i]));
    end
    tx_enable_in <= 1'b0;
    repeat (2) tick();
    check(64'(tx_active_out), 64'd0);
    check(64'(takes), 64'((lc == 2'b10) ? 3 : lim + 8'(lc)));
    check(64'(underflow_out), 64'd0);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence: reset values, frames, stream sources, register map
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    check(64'(cfg_out), 64'(tpc_pkg::CFG_RST));
    for (int j = 0; j < 3; j++) frame(2'(j));
    for (int s = 1; s < 4; s++) begin
      wr(tpc_pkg::ADDR_PKT_CONTROL, {2'b00, 2'(s), 4'h0});
      check(64'(cfg_out.tx_data_source_select), 64'(s));
      tx_enable_in <= 1'b1;
      pn = tpc_pkg::PN9_SEED;
      // let the framer reach stream state before the first tick
      repeat (2) @(posedge mclk_in);
      repeat (16) begin
        pin_in <= 1'($random(seed));
        tick();
        if (s != 2) check(64'(tx_bit_out), 64'(pin_in));
        else check(64'(tx_bit_out), 64'(pn[0]));
        if (s == 2) pn = pn9_next(pn);
        check(64'(tx_active_out), 64'd1);
      end
      tx_enable_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
    end
    // second reset mid-run, then every register: reset value, write, read back
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    for (int i = 0; i < 7; i++) begin
      rd_chk(ra[i], rv[i]);
      d = 8'($random(seed));
      if (i == 3) d = d & 8'h77 & ~{6'h00, d[1], 1'b0};
      wr(ra[i], d);
      rd_chk(ra[i], d & rm[i]);
    end
    wr(6'h07, 8'h5a);
    rd_chk(6'h07, 8'h00);
    end_of_test();
  end
endmodule
